// file: common/tmc_pkg.sv
// package for the dual 8-bit timer mode and carrier control block
// assumes an apb4 master on sys_clk and an outside compare datapath
package tmc_pkg;

  localparam int TMC_NCH = 2;

  // register indices; byte address is four times the index
  localparam logic [31:0] TMC_IDX_MODE0 = 32'h0ffff580;
  localparam logic [31:0] TMC_IDX_CC0 = 32'h0ffff581;
  localparam logic [31:0] TMC_IDX_MODE1 = 32'hfffff590;
  localparam logic [31:0] TMC_IDX_CC1 = 32'hfffff591;
  localparam int TMC_IDX_BITS = 10;

  // reset values
  localparam logic [7:0] TMC_MODE_RST = 8'h00;
  localparam logic [7:0] TMC_CC_RST = 8'h00;

  // mode register field positions
  localparam int TMC_RUN_BIT = 7;
  localparam int TMC_CKS_LSB = 4;
  localparam int TMC_MD_LSB = 2;
  localparam int TMC_LEV_BIT = 1;
  localparam int TMC_OEN_BIT = 0;

  // carrier control field positions
  localparam int TMC_RSEL_BIT = 2;
  localparam int TMC_LBUF_BIT = 1;
  localparam int TMC_STAT_BIT = 0;

  // count clock codes
  localparam logic [2:0] TMC_CKS_DIV1 = 3'h0;
  localparam logic [2:0] TMC_CKS_DIV2 = 3'h1;
  localparam logic [2:0] TMC_CKS_DIV4 = 3'h2;
  localparam logic [2:0] TMC_CKS_DIV16 = 3'h3;
  localparam logic [2:0] TMC_CKS_DIV64 = 3'h4;
  localparam logic [2:0] TMC_CKS_SUB = 3'h5;

  // prescaler masks: tick when the low bits are all ones
  localparam int TMC_DIV_W = 6;
  localparam logic [5:0] TMC_MASK2 = 6'h01;
  localparam logic [5:0] TMC_MASK4 = 6'h03;
  localparam logic [5:0] TMC_MASK16 = 6'h0f;
  localparam logic [5:0] TMC_MASK64 = 6'h3f;

  typedef enum logic [1:0] {
    TMC_INTERVAL,
    TMC_CARRIER,
    TMC_PWM,
    TMC_BADMODE
  } tmc_mode_e;

  typedef struct packed {
    logic [7:0] mode;
    logic remoteSel;
    logic levelBuf;
    logic status;
    logic [7:0] count;
    logic cmpSel;
    logic toLevel;
    logic timerOut;
    logic remoteOut;
    logic matchPulse;
  } tmc_chan_s;

  typedef struct packed {
    tmc_chan_s [TMC_NCH-1:0] ch;
    logic [TMC_DIV_W-1:0] div;
    logic [2:0] subSync;
    logic [31:0] prdata;
    logic slvErr;
  } tmc_state_s;

  localparam tmc_state_s TMC_STATE_RST = '0;

endpackage

// file: design/tmc_timer_ctrl.sv
// two 8-bit timers: mode and carrier control, apb4 slave, count logic
// assumes compare values come from outside on sys_clk; subclock is a pin
// Behaviour
// - clearing run-enable stops counting and forces the counter to zero
// - setting run-enable starts counting on the next count clock tick
// - clock select picks fxx, /2, /4, /16, /64 or subclock; others barred
// - mode field: interval 00, carrier 01, pwm 10; 11 is barred
// - idle-level bit gives the timer output level when idle
// - remote output: low, high, low, or carrier pulse per the two bits
// - carrier status reads 0 when carrier disabled, 1 when enabled
// - carrier status is read-only
// - reset clears carrier control; byte and bit access accepted
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module tmc_timer_ctrl (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic subclockIn,
  input wire logic [tmc_pkg::TMC_NCH-1:0][7:0] compare0,
  input wire logic [tmc_pkg::TMC_NCH-1:0][7:0] compare1,
  output logic [tmc_pkg::TMC_NCH-1:0][7:0] countValue,
  output logic [tmc_pkg::TMC_NCH-1:0] matchPulse,
  output logic [tmc_pkg::TMC_NCH-1:0] timerOut,
  output logic [tmc_pkg::TMC_NCH-1:0] remoteOut,
  output logic [tmc_pkg::TMC_NCH-1:0] carrierStatus
);

  tmc_pkg::tmc_state_s st_q;
  tmc_pkg::tmc_state_s st_d;
  logic [tmc_pkg::TMC_NCH-1:0] chTick;
  logic [tmc_pkg::TMC_NCH-1:0] selMode;
  logic [tmc_pkg::TMC_NCH-1:0] selCc;
  logic subEdge;
  logic setupPh;
  logic accessWr;
  logic [tmc_pkg::TMC_IDX_BITS-1:0] regIdx;

  assign regIdx = paddr[tmc_pkg::TMC_IDX_BITS+1:2];
  assign setupPh = psel & ~penable;
  // zero wait states: read data was caught in the setup cycle
  assign pready = psel & penable;
  assign accessWr = psel & penable & pwrite & pstrb[0];

  always_comb begin
    tmc_pkg::tmc_mode_e md;
    logic [7:0] target;
    logic [2:0] cks;
    logic run;
    logic hit;
    logic [31:0] rd;
    logic err;
    md = tmc_pkg::TMC_INTERVAL;
    target = 8'h00;
    cks = 3'h0;
    run = 1'b0;
    hit = 1'b0;
    rd = 32'h00000000;
    err = 1'b0;
    st_d = st_q;
    st_d.div = st_q.div + 6'h01;
    // only the second stage reads the first
    st_d.subSync = {st_q.subSync[1:0], subclockIn};
    subEdge = st_q.subSync[1] & ~st_q.subSync[2];
    selMode = '0;
    selCc = '0;
    chTick = '0;

    // address decoding
    if (regIdx == tmc_pkg::TMC_IDX_MODE0[tmc_pkg::TMC_IDX_BITS-1:0]) begin
      selMode[0] = 1'b1;
    end else if (regIdx ==
                 tmc_pkg::TMC_IDX_CC0[tmc_pkg::TMC_IDX_BITS-1:0]) begin
      selCc[0] = 1'b1;
    end else if (regIdx ==
                 tmc_pkg::TMC_IDX_MODE1[tmc_pkg::TMC_IDX_BITS-1:0]) begin
      selMode[1] = 1'b1;
    end else if (regIdx ==
                 tmc_pkg::TMC_IDX_CC1[tmc_pkg::TMC_IDX_BITS-1:0]) begin
      selCc[1] = 1'b1;
    end else begin
      err = 1'b1;
    end

    for (int c = 0; c < tmc_pkg::TMC_NCH; c++) begin
      if (selMode[c]) begin
        rd = {24'h000000, st_q.ch[c].mode};
      end
      if (selCc[c]) begin
        rd = {29'h00000000, st_q.ch[c].remoteSel, st_q.ch[c].levelBuf,
              st_q.ch[c].status};
      end
    end
    if (setupPh) begin
      st_d.prdata = rd;
      st_d.slvErr = err;
    end

    for (int c = 0; c < tmc_pkg::TMC_NCH; c++) begin
      // writes; byte lane 0 carries the whole register
      if (accessWr && selMode[c]) begin
        st_d.ch[c].mode = pwdata[7:0];
      end
      if (accessWr && selCc[c]) begin
        st_d.ch[c].remoteSel = pwdata[tmc_pkg::TMC_RSEL_BIT];
        st_d.ch[c].levelBuf = pwdata[tmc_pkg::TMC_LBUF_BIT];
      end
      // status follows the control bits, never the write data
      st_d.ch[c].status = st_q.ch[c].remoteSel &
                          st_q.ch[c].levelBuf;

      cks = st_q.ch[c].mode[tmc_pkg::TMC_CKS_LSB +: 3];
      md = tmc_pkg::tmc_mode_e'(st_q.ch[c].mode[tmc_pkg::TMC_MD_LSB +: 2]);
      run = st_q.ch[c].mode[tmc_pkg::TMC_RUN_BIT];
      // barred codes give no tick, so the counter just holds
      if (cks == tmc_pkg::TMC_CKS_DIV1) begin
        chTick[c] = 1'b1;
      end else if (cks == tmc_pkg::TMC_CKS_DIV2) begin
        chTick[c] = (st_q.div & tmc_pkg::TMC_MASK2) == tmc_pkg::TMC_MASK2;
      end else if (cks == tmc_pkg::TMC_CKS_DIV4) begin
        chTick[c] = (st_q.div & tmc_pkg::TMC_MASK4) == tmc_pkg::TMC_MASK4;
      end else if (cks == tmc_pkg::TMC_CKS_DIV16) begin
        chTick[c] = (st_q.div & tmc_pkg::TMC_MASK16) ==
                    tmc_pkg::TMC_MASK16;
      end else if (cks == tmc_pkg::TMC_CKS_DIV64) begin
        chTick[c] = (st_q.div & tmc_pkg::TMC_MASK64) ==
                    tmc_pkg::TMC_MASK64;
      end else if (cks == tmc_pkg::TMC_CKS_SUB) begin
        chTick[c] = subEdge;
      end else begin
        chTick[c] = 1'b0;
      end

      target = st_q.ch[c].cmpSel ? compare1[c] : compare0[c];
      hit = st_q.ch[c].count == target;
      st_d.ch[c].matchPulse = 1'b0;
      if (!run) begin
        st_d.ch[c].count = 8'h00;
        st_d.ch[c].cmpSel = 1'b0;
        st_d.ch[c].toLevel = st_q.ch[c].mode[tmc_pkg::TMC_LEV_BIT];
      end else if (chTick[c]) begin
        case (md)
          tmc_pkg::TMC_INTERVAL: begin
            st_d.ch[c].cmpSel = 1'b0;
            if (hit) begin
              st_d.ch[c].count = 8'h00;
              st_d.ch[c].toLevel = ~st_q.ch[c].toLevel;
              st_d.ch[c].matchPulse = 1'b1;
            end else begin
              st_d.ch[c].count = 8'(st_q.ch[c].count + 8'h01);
            end
          end
          tmc_pkg::TMC_PWM: begin
            if (hit) begin
              st_d.ch[c].toLevel = ~st_q.ch[c].toLevel;
              st_d.ch[c].cmpSel = ~st_q.ch[c].cmpSel;
              // the duty match leaves the counter running
              if (!st_q.ch[c].cmpSel) begin
                st_d.ch[c].count = 8'h00;
                st_d.ch[c].matchPulse = 1'b1;
              end else begin
                st_d.ch[c].count = 8'(st_q.ch[c].count + 8'h01);
              end
            end else begin
              st_d.ch[c].count = 8'(st_q.ch[c].count + 8'h01);
            end
          end
          tmc_pkg::TMC_CARRIER: begin
            // each half of the carrier restarts the counter
            if (hit) begin
              st_d.ch[c].count = 8'h00;
              st_d.ch[c].toLevel = ~st_q.ch[c].toLevel;
              st_d.ch[c].cmpSel = ~st_q.ch[c].cmpSel;
              st_d.ch[c].matchPulse = ~st_q.ch[c].cmpSel;
            end else begin
              st_d.ch[c].count = 8'(st_q.ch[c].count + 8'h01);
            end
          end
          default: begin
            st_d.ch[c].count = st_q.ch[c].count;
          end
        endcase
      end
      if (st_q.ch[c].mode[tmc_pkg::TMC_OEN_BIT]) begin
        st_d.ch[c].timerOut = st_q.ch[c].toLevel;
      end else begin
        st_d.ch[c].timerOut = st_q.ch[c].mode[tmc_pkg::TMC_LEV_BIT];
      end
      // carrier pulse only with both bits set
      if (st_q.ch[c].remoteSel) begin
        st_d.ch[c].remoteOut = st_q.ch[c].levelBuf & st_q.ch[c].toLevel;
      end else begin
        st_d.ch[c].remoteOut = st_q.ch[c].levelBuf;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= tmc_pkg::TMC_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pslverr = pready & st_q.slvErr;
  for (genvar g = 0; g < tmc_pkg::TMC_NCH; g++) begin : gOut
    assign countValue[g] = st_q.ch[g].count;
    assign matchPulse[g] = st_q.ch[g].matchPulse;
    assign timerOut[g] = st_q.ch[g].timerOut;
    assign remoteOut[g] = st_q.ch[g].remoteOut;
    assign carrierStatus[g] = st_q.ch[g].status;
  end

  // checks on channel 0; channel 1 is the same logic in the loop
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  stop_clears_a: assert property (
    !st_q.ch[0].mode[7] |=> st_q.ch[0].count == 8'h00)
    else $error("counter not zero while stopped");

  start_count_a: assert property (
    st_q.ch[0].mode[7] && chTick[0] && st_q.ch[0].mode[3:2] != 2'h3 &&
    st_q.ch[0].count != (st_q.ch[0].cmpSel ? compare1[0] : compare0[0])
    |=> st_q.ch[0].count == 8'($past(st_q.ch[0].count) + 8'h01))
    else $error("counter did not advance on tick");

  bad_clock_a: assert property (
    st_q.ch[0].mode[6:4] > 3'h5 |-> !chTick[0])
    else $error("tick from barred clock code");

  div64_tick_a: assert property (
    st_q.ch[0].mode[6:4] == 3'h4 && chTick[0] |=>
    (!chTick[0] || st_q.ch[0].mode[6:4] != 3'h4) [*8])
    else $error("fxx/64 ticks too close");

  bad_mode_a: assert property (
    st_q.ch[0].mode[7] && st_q.ch[0].mode[3:2] == 2'h3 &&
    $past(st_q.ch[0].mode) == st_q.ch[0].mode
    |=> $stable(st_q.ch[0].count))
    else $error("counting in barred mode");

  idle_level_a: assert property (
    !st_q.ch[0].mode[7] && !$past(st_q.ch[0].mode[7]) &&
    $stable(st_q.ch[0].mode) ##1 $stable(st_q.ch[0].mode)
    |=> timerOut[0] == $past(st_q.ch[0].mode[1]))
    else $error("timer output not at idle level");

  remote_out_a: assert property (
    1'b1 |=> remoteOut[0] == ($past(st_q.ch[0].remoteSel) ?
      ($past(st_q.ch[0].levelBuf) & $past(st_q.ch[0].toLevel)) :
      $past(st_q.ch[0].levelBuf)))
    else $error("remote output wrong");

  carrier_flag_a: assert property (
    st_q.ch[0].remoteSel && st_q.ch[0].levelBuf &&
    $stable(st_q.ch[0].remoteSel) && $stable(st_q.ch[0].levelBuf)
    |=> carrierStatus[0])
    else $error("carrier status not set");

  status_ro_a: assert property (
    accessWr && selCc[0] && !st_q.ch[0].remoteSel |=> !carrierStatus[0])
    else $error("status changed by write");

  reset_clear_a: assert property (@(posedge sys_clk)
    disable iff (1'b0)
    srst |=> st_q.ch[0].remoteSel == 1'b0 &&
    st_q.ch[0].levelBuf == 1'b0 && !carrierStatus[0])
    else $error("carrier control not cleared");

  upper_zero_a: assert property (
    pready && !pwrite && selCc[0] |-> prdata[31:3] == 29'h00000000)
    else $error("carrier control upper bits set");

  pwm_run_c: cover property (
    st_q.ch[0].mode[3:2] == 2'h2 && matchPulse[0] ##[1:600] matchPulse[0]);
  carrier_run_c: cover property (
    st_q.ch[0].mode[3:2] == 2'h1 && remoteOut[0] ##1 !remoteOut[0]);
  interval_run_c: cover property (
    st_q.ch[0].mode[3:2] == 2'h0 && matchPulse[0]);
  sub_tick_c: cover property (st_q.ch[0].mode[6:4] == 3'h5 && chTick[0]);

endmodule

// file: tb/tb_top.sv
// self-checking bench for the dual timer mode and carrier control block
// assumes a zero-wait apb slave and registered timer outputs
`timescale 1ns/1ns
module tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic subclockIn = 1'b0;
  logic [tmc_pkg::TMC_NCH-1:0][7:0] compare0 = '0;
  logic [tmc_pkg::TMC_NCH-1:0][7:0] compare1 = '0;
  logic [tmc_pkg::TMC_NCH-1:0][7:0] countValue;
  logic [tmc_pkg::TMC_NCH-1:0] matchPulse;
  logic [tmc_pkg::TMC_NCH-1:0] timerOut;
  logic [tmc_pkg::TMC_NCH-1:0] remoteOut;
  logic [tmc_pkg::TMC_NCH-1:0] carrierStatus;
  logic [32:0] expQ[$];
  logic [32:0] note;
  logic [31:0] rnd;
  logic [1:0] ccVal;
  logic [7:0] curMode[2] = '{8'h00, 8'h00};
  logic probe;
  int errors = 0;
  int check_count = 0;
  int subCnt = 0;
  int pSel = 0;
  int pCh = 0;
  int hi;
  int lo;
  int divs[6] = '{1, 2, 4, 16, 64, 10};

  tmc_timer_ctrl dut (.sys_clk(sys_clk), .srst(srst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .subclockIn(subclockIn), .compare0(compare0), .compare1(compare1),
    .countValue(countValue), .matchPulse(matchPulse),
    .timerOut(timerOut), .remoteOut(remoteOut),
    .carrierStatus(carrierStatus));

  always #25 sys_clk = ~sys_clk;

  // subclock period is ten system cycles
  always @(posedge sys_clk) begin
    subCnt <= (subCnt == 4) ? 0 : subCnt + 1;
    if (subCnt == 4) begin
      subclockIn <= ~subclockIn;
    end
  end

  always_comb begin
    case (pSel)
      0: probe = timerOut[pCh];
      1: probe = remoteOut[pCh];
      default: probe = matchPulse[pCh];
    endcase
  end

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  // read notes are taken off the queue when the access completes
  always @(posedge sys_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && expQ.size() > 0) begin
      note = expQ.pop_front();
      check("prdata", note[31:0], prdata);
      check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
    end
  end

  task automatic apb(input logic [31:0] idx, input logic wr,
                     input logic [31:0] wd, input logic [3:0] sb,
                     input logic [32:0] e);
    int n;
    n = 0;
    @(posedge sys_clk);
    paddr <= {idx[29:0], 2'b00};
    pwrite <= wr;
    pwdata <= wd;
    pstrb <= sb;
    psel <= 1'b1;
    if (!wr) begin
      expQ.push_back(e);
    end
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] mreg(input int ch);
    return ch ? tmc_pkg::TMC_IDX_MODE1 : tmc_pkg::TMC_IDX_MODE0;
  endfunction

  function automatic logic [31:0] creg(input int ch);
    return ch ? tmc_pkg::TMC_IDX_CC1 : tmc_pkg::TMC_IDX_CC0;
  endfunction

  // stop with fields kept, change fields only while stopped
  task automatic start(input int ch, input logic [7:0] md,
                       input logic [7:0] c0, input logic [7:0] c1);
    if (curMode[ch][7]) begin
      apb(mreg(ch), 1'b1, {25'h0, curMode[ch][6:0]}, 4'h1, '0);
    end
    apb(mreg(ch), 1'b1, {25'h0, md[6:0]}, 4'h1, '0);
    compare0[ch] <= c0;
    compare1[ch] <= c1;
    apb(mreg(ch), 1'b1, {24'h0, md}, 4'h1, '0);
    curMode[ch] = md;
  endtask

  // width of one high and the following low phase of the probe
  task automatic measure(output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while (probe !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    while (probe !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    while (probe === 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      h++;
      n++;
    end
    while (probe === 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      l++;
      n++;
    end
    check("probe bounded", 32'h0, {31'h0, n >= 3000});
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(50 * 60000);
    errors++;
    final_report();
  end

  initial begin
    rnd = $urandom(32'h37ac);
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    for (int ch = 0; ch < 2; ch++) begin
      apb(mreg(ch), 1'b0, 0, 4'h0, 33'h0);
      apb(creg(ch), 1'b0, 0, 4'h0, 33'h0);
      // every select and level pair, each level, status write attempted
      for (int k = 0; k < 8; k++) begin
        apb(mreg(ch), 1'b1, {30'h0, k[2], 1'b0}, 4'h1, '0);
        apb(creg(ch), 1'b1, {27'h7ff_ffff, k[1:0], ~&k[1:0]}, 4'h1, '0);
        apb(creg(ch), 1'b0, 0, 4'h0, {30'h0, k[1:0], &k[1:0]});
        check("remoteOut", k[1] ? k[0] & k[2] : k[0], remoteOut[ch]);
        check("carrierStatus", &k[1:0], carrierStatus[ch]);
        check("idle timerOut", k[2], timerOut[ch]);
      end
    end
    ccVal = 2'h3;
    repeat (8) begin
      rnd = $urandom;
      apb(tmc_pkg::TMC_IDX_CC0, 1'b1, rnd, {3'h0, rnd[8]}, '0);
      ccVal = rnd[8] ? rnd[2:1] : ccVal;
      apb(tmc_pkg::TMC_IDX_CC0, 1'b0, 0, 4'h0, {30'h0, ccVal, &ccVal});
    end
    apb(32'h0, 1'b0, 0, 4'h0, {1'b1, 32'h0});
    // interval timer on every count clock source, output toggles per match
    for (int c = 0; c < 6; c++) begin
      start(0, {1'b1, c[2:0], 4'h1}, 8'h03, 8'h00);
      measure(hi, lo);
      check("interval high", 4 * divs[c], hi);
      check("interval low", 4 * divs[c], lo);
    end
    start(0, 8'h03, 8'h03, 8'h00);
    repeat (3) @(posedge sys_clk);
    check("stopped count", 8'h00, countValue[0]);
    check("stopped out", 1'b1, timerOut[0]);
    // barred clock code and barred mode both leave the counter still
    start(0, 8'he1, 8'hff, 8'hff);
    repeat (4) @(posedge sys_clk);
    check("barred clock count", 8'h00, countValue[0]);
    start(0, 8'h8d, 8'hff, 8'hff);
    repeat (4) @(posedge sys_clk);
    check("barred mode count", 8'h00, countValue[0]);
    pCh = 1;
    pSel = 2;
    start(1, 8'h81, 8'h05, 8'h00);
    measure(hi, lo);
    check("match pulse", 1, hi);
    check("match gap", 5, lo);
    pSel = 0;
    start(1, 8'h89, 8'h07, 8'h02);
    measure(hi, lo);
    check("pwm high", 3, hi);
    check("pwm low", 5, lo);
    apb(creg(1), 1'b1, 32'h06, 4'h1, '0);
    // carrier mode on the fxx count clock, remote output set to pass the carrier
    start(1, 8'h85, 8'h07, 8'h02);
    measure(hi, lo);
    check("carrier high", 3, hi);
    check("carrier low", 8, lo);
    pSel = 1;
    measure(hi, lo);
    check("remote high", 3, hi);
    check("remote low", 8, lo);
    final_report();
  end
endmodule
